// File: design/ctb_pkg.sv
// Purpose: Shared constants and types for the CAN transmit-buffer request/result block
// Assumes: 32-bit AXI4-Lite register bus, one transmit buffer
// Notes:   Offsets are byte addresses of aligned words
package ctb_pkg;

  localparam int          CTB_ADDR_W       = 8;
  localparam int          CTB_DATA_W       = 32;

  localparam logic [7:0]  CTB_OFF_TX_CTRL  = 8'h00;
  localparam logic [7:0]  CTB_OFF_TX_STAT  = 8'h04;
  localparam logic [7:0]  CTB_OFF_CH_CTRL  = 8'h08;
  localparam logic [7:0]  CTB_OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0]  CTB_OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0]  CTB_OFF_TX_DATA  = 8'h14;

  // Control word bit positions
  localparam int          CTB_BIT_REQ      = 0;
  localparam int          CTB_BIT_ABRQ     = 1;
  localparam int          CTB_BIT_ONESHOT  = 2;
  // Status word: result in [1:0], attempt on the bus in bit 2
  localparam int          CTB_BIT_BUSY     = 2;
  // Channel control and interrupt layouts
  localparam int          CTB_BIT_ABT_EN   = 0;
  localparam int          CTB_BIT_CMP_EN   = 1;
  localparam int          CTB_IRQ_CMP      = 0;
  localparam int          CTB_IRQ_ABT      = 1;

  localparam logic [1:0]  CTB_RES_BUSY     = 2'h0;
  localparam logic [1:0]  CTB_RES_ABORTED  = 2'h1;
  localparam logic [1:0]  CTB_RES_DONE     = 2'h2;
  localparam logic [1:0]  CTB_RES_DONE_AB  = 2'h3;

  localparam logic [1:0]  CTB_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  CTB_RESP_SLVERR  = 2'h2;

  typedef enum logic [0:0] {CTB_IDLE, CTB_WAIT} ctb_state_t;

  typedef struct packed {
    logic one_shot;
    logic abort;
    logic request;
  } ctb_req_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] code;
  } ctb_fin_t;

  typedef struct packed {
    logic done;
    logic arb_lost;
    logic error;
  } ctb_bus_ev_t;

  function automatic logic [31:0] ctb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : ctb_merge

endpackage : ctb_pkg

// File: design/ctb_tx_attempt.sv
// Purpose: One transmit attempt sequencer facing the CAN protocol engine
// Assumes: Engine reports exactly one of done, arbitration lost or error per attempt
// Notes:   Finish code is a one-cycle pulse read by the register file
`timescale 1ns/1ps
module ctb_tx_attempt
  import ctb_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        go,
  input  wire ctb_req_t    req,
  input  wire logic [31:0] frame_in,
  input  wire ctb_bus_ev_t bus_ev,
  output logic             tx_start,
  output logic [31:0]      tx_frame,
  output logic             busy,
  output ctb_fin_t         fin
);

  typedef struct packed {
    ctb_state_t  st;
    logic        start;
    logic [31:0] frame;
    ctb_fin_t    fin;
  } ctb_att_t;

  ctb_att_t s;
  ctb_att_t next_s;

  always_comb
  begin
    next_s       = s;
    next_s.start = 1'b0;
    next_s.fin   = '0;
    case (s.st)
      CTB_IDLE:
      begin
        // Skip the cycle of a finish, the request is cleared only one edge later
        if (go && !s.fin.valid)
        begin
          next_s.st    = CTB_WAIT;
          next_s.start = 1'b1;
          next_s.frame = frame_in;
        end
      end
      CTB_WAIT:
      begin
        if (bus_ev.done)
        begin
          next_s.st        = CTB_IDLE;
          next_s.fin.valid = 1'b1;
          next_s.fin.code  = req.abort ? CTB_RES_DONE_AB : CTB_RES_DONE;
        end
        else if (bus_ev.arb_lost || bus_ev.error)
        begin
          next_s.st = CTB_IDLE;
          // Plain request stays pending and is retried from idle
          if (req.abort || req.one_shot)
          begin
            next_s.fin.valid = 1'b1;
            next_s.fin.code  = CTB_RES_ABORTED;
          end
        end
      end
      default: next_s = '0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign tx_start = s.start;
  assign tx_frame = s.frame;
  assign busy     = (s.st == CTB_WAIT);
  assign fin      = s.fin;

  property p_fail_retry;
    @(posedge aclk) disable iff (!aresetn)
      (busy && !bus_ev.done && (bus_ev.arb_lost || bus_ev.error) && !req.abort && !req.one_shot)
      |=> !fin.valid && !busy;
  endproperty
  a_fail_retry: assert property (p_fail_retry) else $error("failed plain attempt gave a finish");

endmodule : ctb_tx_attempt

// File: design/ctb_tx_buffer.sv
// Purpose: Transmit-buffer request and result logic with AXI4-Lite registers
// Assumes: Protocol engine handles bit timing, reports each attempt's outcome as pulses
// Notes:   Interrupt sticky bits are cleared by writing one
//
// Functional notes
// - Plain request success gives result 10, complete irq
// - Plain request failure keeps 00, retries, no irq
// - Success with abort pending gives 11, complete irq
// - Abort or one-shot failure gives 01, abort irq
// - One-shot tries once; success gives 10 or 11
// - Abort irq reaches output only when enabled
`timescale 1ns/1ps
module ctb_tx_buffer
  import ctb_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [CTB_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [CTB_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [CTB_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [CTB_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire ctb_bus_ev_t           can_ev,
  output logic                       can_tx_start,
  output logic [31:0]                can_tx_frame,
  output logic                       irq
);

  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic                  aw_got;
    logic                  w_got;
    logic [CTB_ADDR_W-1:0] aw_addr;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
    ctb_req_t              req;
    logic [1:0]            result;
    logic                  abt_en;
    logic                  cmp_en;
    logic [1:0]            irq_st;
    logic [1:0]            irq_mk;
    logic [31:0]           frame;
    logic                  irq;
  } ctb_main_t;

  ctb_main_t   s;
  ctb_main_t   next_s;
  logic        go;
  logic        busy;
  ctb_fin_t    fin;

  // A new attempt only while the previous result has been acknowledged
  assign go = s.req.request && (s.result == CTB_RES_BUSY);

  ctb_tx_attempt u_attempt (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .go       (go),
    .req      (s.req),
    .frame_in (s.frame),
    .bus_ev   (can_ev),
    .tx_start (can_tx_start),
    .tx_frame (can_tx_frame),
    .busy     (busy),
    .fin      (fin)
  );

  always_comb
  begin
    logic [31:0] v;
    logic        wr_do;
    v      = '0;
    wr_do  = s.aw_got && s.w_got && !s.bvalid;
    next_s = s;
    if (s_axi_awvalid && s.awready)
    begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready)
    begin
      next_s.w_got  = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;
    if (wr_do)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = CTB_RESP_OKAY;
      case (s.aw_addr)
        CTB_OFF_TX_CTRL:
        begin
          v = ctb_merge(32'(s.req), s.w_data, s.w_strb);
          // Writes without the request bit, or before acknowledge, are ignored
          if (v[CTB_BIT_REQ] && s.result == CTB_RES_BUSY)
          begin
            next_s.req.request  = 1'b1;
            next_s.req.abort    = s.req.abort || v[CTB_BIT_ABRQ];
            next_s.req.one_shot = s.req.one_shot || v[CTB_BIT_ONESHOT];
          end
        end
        CTB_OFF_TX_STAT:
        begin
          v = ctb_merge(32'(s.result), s.w_data, s.w_strb);
          if (v[1:0] == CTB_RES_BUSY)
            next_s.result = CTB_RES_BUSY;
        end
        CTB_OFF_CH_CTRL:
        begin
          v = ctb_merge({30'h0, s.cmp_en, s.abt_en}, s.w_data, s.w_strb);
          next_s.abt_en = v[CTB_BIT_ABT_EN];
          next_s.cmp_en = v[CTB_BIT_CMP_EN];
        end
        CTB_OFF_IRQ_STAT:
        begin
          v = ctb_merge(32'h0000_0000, s.w_data, s.w_strb);
          next_s.irq_st = s.irq_st & ~v[1:0];
        end
        CTB_OFF_IRQ_MASK:
        begin
          v = ctb_merge(32'(s.irq_mk), s.w_data, s.w_strb);
          next_s.irq_mk = v[1:0];
        end
        CTB_OFF_TX_DATA: next_s.frame = ctb_merge(s.frame, s.w_data, s.w_strb);
        default: next_s.bresp = CTB_RESP_SLVERR;
      endcase
    end
    // Hardware finish comes after software writes, so a same-cycle set wins
    if (fin.valid)
    begin
      next_s.result = fin.code;
      next_s.req    = '0;
      if (fin.code == CTB_RES_ABORTED)
        next_s.irq_st[CTB_IRQ_ABT] = 1'b1;
      else
        next_s.irq_st[CTB_IRQ_CMP] = 1'b1;
    end
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
    if (s_axi_arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = CTB_RESP_OKAY;
      case (s_axi_araddr)
        CTB_OFF_TX_CTRL:  next_s.rdata = 32'(s.req);
        CTB_OFF_TX_STAT:  next_s.rdata = {29'h0, busy, s.result};
        CTB_OFF_CH_CTRL:  next_s.rdata = {30'h0, s.cmp_en, s.abt_en};
        CTB_OFF_IRQ_STAT: next_s.rdata = {30'h0, s.irq_st};
        CTB_OFF_IRQ_MASK: next_s.rdata = {30'h0, s.irq_mk};
        CTB_OFF_TX_DATA:  next_s.rdata = s.frame;
        default:
        begin
          next_s.rdata = '0;
          next_s.rresp = CTB_RESP_SLVERR;
        end
      endcase
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready  = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
    // Enables sit in front of the pin so masked-off sources still show in status
    next_s.irq = (next_s.irq_st[CTB_IRQ_CMP] && next_s.irq_mk[CTB_IRQ_CMP] && next_s.cmp_en)
              || (next_s.irq_st[CTB_IRQ_ABT] && next_s.irq_mk[CTB_IRQ_ABT] && next_s.abt_en);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rdata   = s.rdata;
  assign irq           = s.irq;

  sequence s_ok_plain;
    busy && can_ev.done && !s.req.abort;
  endsequence
  sequence s_ok_abrq;
    busy && can_ev.done && s.req.abort;
  endsequence
  sequence s_fail_stop;
    busy && !can_ev.done && (can_ev.arb_lost || can_ev.error) && (s.req.abort || s.req.one_shot);
  endsequence
  sequence s_fail_plain;
    busy && !can_ev.done && (can_ev.arb_lost || can_ev.error) && !s.req.abort && !s.req.one_shot;
  endsequence

  property p_done_plain;
    @(posedge aclk) disable iff (!aresetn)
      s_ok_plain |=> fin.valid ##1 (s.result == CTB_RES_DONE && s.irq_st[CTB_IRQ_CMP]);
  endproperty
  a_done_plain: assert property (p_done_plain) else $error("plain success result wrong");

  property p_keep_pending;
    @(posedge aclk) disable iff (!aresetn)
      s_fail_plain |=> ##1 (s.result == CTB_RES_BUSY && s.req.request && $stable(s.irq_st));
  endproperty
  a_keep_pending: assert property (p_keep_pending) else $error("plain failure changed result");

  property p_done_abrq;
    @(posedge aclk) disable iff (!aresetn)
      s_ok_abrq |=> ##1 (s.result == CTB_RES_DONE_AB && s.irq_st[CTB_IRQ_CMP]);
  endproperty
  a_done_abrq: assert property (p_done_abrq) else $error("success with abort result wrong");

  property p_aborted;
    @(posedge aclk) disable iff (!aresetn)
      s_fail_stop |=> ##1 (s.result == CTB_RES_ABORTED && s.irq_st[CTB_IRQ_ABT]);
  endproperty
  a_aborted: assert property (p_aborted) else $error("abort result wrong");

  property p_one_shot;
    @(posedge aclk) disable iff (!aresetn)
      (s_fail_stop and (s.req.one_shot)) |=> (!can_tx_start)[*4];
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot frame retried");

  property p_abt_gate;
    @(posedge aclk) disable iff (!aresetn)
      (!s.abt_en && !(s.irq_st[CTB_IRQ_CMP] && s.irq_mk[CTB_IRQ_CMP] && s.cmp_en)) |-> !irq;
  endproperty
  a_abt_gate: assert property (p_abt_gate) else $error("abort irq delivered while disabled");

  property p_req_clear;
    @(posedge aclk) disable iff (!aresetn)
      fin.valid |=> (s.req == '0 && s.result == $past(fin.code));
  endproperty
  a_req_clear: assert property (p_req_clear) else $error("request bits kept after final result");

endmodule : ctb_tx_buffer

// File: testbench/can_tx_buffer_request_result_tb_top.sv
// Purpose: Self-checking bench for the transmit-buffer request and result block
// Assumes: Register access over AXI4-Lite, node model answers each attempt
// Notes:   Ready and valid are sampled at the falling edge ahead of the taking edge
`timescale 1ns/1ps
module can_tx_buffer_request_result_tb_top;
  import ctb_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, lat = 8'h02;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, q_data;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, can_tx_start, irq;
  logic [1:0] bresp, rresp, q_resp, kind = 2'h0;
  logic [31:0] can_tx_frame;
  ctb_bus_ev_t can_ev;
  int num_errors = 0, checks = 0, starts = 0;

  always #50 aclk = ~aclk;
  always @(posedge aclk) if (can_tx_start === 1'b1) starts <= starts + 1;

  ctb_tx_buffer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .can_ev(can_ev),
    .can_tx_start(can_tx_start), .can_tx_frame(can_tx_frame), .irq(irq));
  ctb_can_node_model node (.aclk(aclk), .aresetn(aresetn), .can_tx_start(can_tx_start), .kind(kind),
    .lat(lat), .can_ev(can_ev));

  task automatic report_and_stop;
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic timed_out;
    num_errors++;
    report_and_stop();
  endtask : timed_out

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hit, w_hit, b_hit;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    for (int i = 0; i < 50; i++)
    begin
      @(negedge aclk);
      aw_hit = awvalid & awready; w_hit = wvalid & wready; b_hit = bvalid;
      q_resp = bresp;
      @(posedge aclk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      if (b_hit)
      begin
        bready <= 1'b0;
        return;
      end
    end
    timed_out();
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    logic ar_hit, r_hit;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int i = 0; i < 50; i++)
    begin
      @(negedge aclk);
      ar_hit = arvalid & arready; r_hit = rvalid;
      q_data = rdata; q_resp = rresp;
      @(posedge aclk);
      if (ar_hit) arvalid <= 1'b0;
      if (r_hit)
      begin
        rready <= 1'b0;
        return;
      end
    end
    timed_out();
  endtask : axi_rd

  // Bounded wait for the result field to leave 00
  task automatic wait_result;
    for (int i = 0; i < 60; i++)
    begin
      axi_rd(CTB_OFF_TX_STAT);
      if (q_data[1:0] !== CTB_RES_BUSY) return;
    end
    timed_out();
  endtask : wait_result

  // Poll for the final result, judge it and the interrupt, then acknowledge both
  task automatic check_final(input logic [1:0] exp_res, input int irq_bit);
    wait_result();
    chk({30'h0, q_data[1:0]}, {30'h0, exp_res});
    @(negedge aclk);
    chk(irq, 1'b1);
    axi_rd(CTB_OFF_IRQ_STAT);
    chk(q_data, 32'h1 << irq_bit);
    axi_rd(CTB_OFF_TX_CTRL);
    chk(q_data, 32'h0);
    axi_wr(CTB_OFF_TX_STAT, 32'h0);
    axi_wr(CTB_OFF_IRQ_STAT, 32'h3);
    axi_rd(CTB_OFF_TX_STAT);
    chk(q_data, 32'h0);
    @(negedge aclk);
    chk(irq, 1'b0);
  endtask : check_final

  // One request with a fixed outcome; aborting modes must not retry
  task automatic run_case(input logic [2:0] ctrl, input logic [1:0] k, input logic [7:0] l,
                          input logic [1:0] exp_res, input int irq_bit);
    int s0;
    s0 = starts;
    kind <= k; lat <= l;
    axi_wr(CTB_OFF_TX_CTRL, {29'h0, ctrl});
    check_final(exp_res, irq_bit);
    chk(starts - s0, 1);
  endtask : run_case

  // Plain request: failures keep 00 and retry silently, then success
  task automatic sc_plain_retry;
    int s0;
    s0 = starts;
    kind <= 2'h1; lat <= 8'h03;
    axi_wr(CTB_OFF_TX_CTRL, 32'h1);
    chk({30'h0, q_resp}, {30'h0, CTB_RESP_OKAY});
    for (int i = 0; i < 200 && starts < s0 + 3; i++) @(posedge aclk);
    kind <= 2'h2;
    // Retries under error too; the attempt count is open while failures repeat
    for (int i = 0; i < 200 && starts < s0 + 5; i++) @(posedge aclk);
    if (starts < s0 + 5) timed_out();
    axi_rd(CTB_OFF_TX_STAT);
    kind <= 2'h0;
    chk({30'h0, q_data[1:0]}, {30'h0, CTB_RES_BUSY});
    @(negedge aclk);
    chk(irq, 1'b0);
    check_final(CTB_RES_DONE, CTB_IRQ_CMP);
    chk(can_tx_frame, 32'hA5C3_1E70);
  endtask : sc_plain_retry

  // Abort failure with the abort enable off: sticky bit set, no line
  task automatic sc_abort_masked;
    axi_wr(CTB_OFF_CH_CTRL, 32'h2);
    kind <= 2'h1; lat <= 8'h02;
    axi_wr(CTB_OFF_TX_CTRL, 32'h3);
    wait_result();
    chk({30'h0, q_data[1:0]}, {30'h0, CTB_RES_ABORTED});
    @(negedge aclk);
    chk(irq, 1'b0);
    axi_wr(CTB_OFF_CH_CTRL, 32'h3);
    @(negedge aclk);
    chk(irq, 1'b1);
    axi_rd(CTB_OFF_CH_CTRL);
    chk(q_data, 32'h3);
    axi_wr(CTB_OFF_IRQ_MASK, 32'h1);
    @(negedge aclk);
    chk(irq, 1'b0);
    axi_wr(CTB_OFF_IRQ_MASK, 32'h3);
    axi_wr(CTB_OFF_TX_STAT, 32'h0);
    axi_wr(CTB_OFF_IRQ_STAT, 32'h3);
  endtask : sc_abort_masked

  // Control write without the request bit starts nothing
  task automatic sc_no_request_bit;
    int s0;
    s0 = starts;
    axi_wr(CTB_OFF_TX_CTRL, 32'h6);
    chk({30'h0, q_resp}, {30'h0, CTB_RESP_OKAY});
    repeat (10) @(posedge aclk);
    chk(starts - s0, 0);
    axi_rd(CTB_OFF_TX_CTRL);
    chk(q_data, 32'h0);
    axi_wr(8'h40, 32'h1);
    chk({30'h0, q_resp}, {30'h0, CTB_RESP_SLVERR});
    axi_rd(8'h40);
    chk({30'h0, q_resp}, {30'h0, CTB_RESP_SLVERR});
    chk(q_data, 32'h0);
  endtask : sc_no_request_bit

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(irq, 1'b0);
    axi_wr(CTB_OFF_TX_DATA, 32'hA5C3_1E70);
    axi_wr(CTB_OFF_IRQ_MASK, 32'h3);
    axi_wr(CTB_OFF_CH_CTRL, 32'h3);
    sc_no_request_bit();
    sc_plain_retry();
    run_case(3'h3, 2'h0, 8'h02, CTB_RES_DONE_AB, CTB_IRQ_CMP);
    run_case(3'h3, 2'h2, 8'h02, CTB_RES_ABORTED, CTB_IRQ_ABT);
    run_case(3'h5, 2'h0, 8'h10, CTB_RES_DONE, CTB_IRQ_CMP);
    run_case(3'h5, 2'h1, 8'h02, CTB_RES_ABORTED, CTB_IRQ_ABT);
    run_case(3'h7, 2'h0, 8'h02, CTB_RES_DONE_AB, CTB_IRQ_CMP);
    run_case(3'h7, 2'h2, 8'h10, CTB_RES_ABORTED, CTB_IRQ_ABT);
    sc_abort_masked();
    report_and_stop();
  end
endmodule : can_tx_buffer_request_result_tb_top

// File: testbench/ctb_can_node_model.sv
// Purpose: Behavioural stand-in for the other nodes and engine on the CAN bus
// Assumes: One outcome pulse per started attempt, after lat+1 idle cycles
// Notes:   kind 0 done, 1 arbitration lost, 2 error; bench picks it per scenario
`timescale 1ns/1ps
module ctb_can_node_model
  import ctb_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       can_tx_start,
  input  wire logic [1:0] kind,
  input  wire logic [7:0] lat,
  output ctb_bus_ev_t     can_ev
);
  logic       active;
  logic [7:0] cnt;

  // Exactly one outcome per attempt, so a retry needs a fresh start pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      active <= 1'b0;
      cnt    <= 8'h00;
      can_ev <= '0;
    end
    else
    begin
      can_ev <= '0;
      if (can_tx_start)
      begin
        active <= 1'b1;
        cnt    <= lat;
      end
      else if (active && cnt == 8'h00)
      begin
        active          <= 1'b0;
        can_ev.done     <= (kind == 2'h0);
        can_ev.arb_lost <= (kind == 2'h1);
        can_ev.error    <= (kind == 2'h2);
      end
      else if (active)
        cnt <= cnt - 8'h01;
    end
  end
endmodule : ctb_can_node_model
